// ---- rtl/atr_pkg.sv ----
// constants shared by the auto-reload timer modules
package atr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ATR_OFS_COUNT = 8'h00;
  localparam logic [7:0] ATR_OFS_RELOAD = 8'h04;
  localparam logic [7:0] ATR_OFS_CLKCFG = 8'h08;
  localparam logic [7:0] ATR_OFS_IRQ_STS = 8'h0c;
  localparam logic [7:0] ATR_OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] ATR_OFS_CTRL = 8'hc8;
  // timer_five_control field positions
  localparam int ATR_B_HI_FLAG = 7;
  localparam int ATR_B_LO_FLAG = 6;
  localparam int ATR_B_LO_IRQ_EN = 5;
  localparam int ATR_B_SPLIT = 3;
  localparam int ATR_B_RUN = 2;
  localparam int ATR_B_EXT_SEL = 0;
  // byte_clock_config_reg field positions
  localparam int ATR_B_HI_PICK = 1;
  localparam int ATR_B_LO_PICK = 0;
  // interrupt status and mask field positions
  localparam int ATR_B_IRQ_HI = 0;
  localparam int ATR_B_IRQ_LO = 1;
  // reset values
  localparam logic [7:0] ATR_CTRL_RST = 8'h00;
  localparam logic [15:0] ATR_COUNT_RST = 16'h0000;
  localparam logic [15:0] ATR_RELOAD_RST = 16'h0000;
  localparam logic [1:0] ATR_CLKCFG_RST = 2'h0;
  localparam logic [1:0] ATR_IRQ_RST = 2'h0;
  // prescaler divide ratios
  localparam int ATR_CORE_DIV = 12;
  localparam int ATR_EXT_DIV = 8;
  // bus responses
  localparam logic [1:0] ATR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ATR_RESP_SLVERR = 2'h2;
endpackage : atr_pkg

// ---- rtl/atr_tick_if.sv ----
// prescaled tick carrier between prescaler and timer core
interface atr_tick_if;
  logic ext_select; // external source chosen
  logic presc_tick; // one-cycle prescaled tick
  modport core (output ext_select, input presc_tick);
  modport presc (input ext_select, output presc_tick);
endinterface : atr_tick_if

// ---- rtl/atr_prescale.sv ----
// prescaler: core clock divided by 12 or external clock divided by 8
module atr_prescale
  import atr_pkg::*;
#(
  parameter int CORE_DIV = atr_pkg::ATR_CORE_DIV,
  parameter int EXT_DIV = atr_pkg::ATR_EXT_DIV
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ext_clk, // external clock pin
  atr_tick_if.presc tick // prescaled tick out
);
  import atr_pkg::*;

  // refuse divide ratios that the 8-bit dividers cannot count
  if (CORE_DIV < 2 || CORE_DIV > 256 ||
      EXT_DIV < 2 || EXT_DIV > 256) begin : g_bad_div
    $error("atr_prescale: divide ratio out of range");
  end

  localparam logic [7:0] CORE_LAST = 8'(CORE_DIV - 1);
  localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

  logic [7:0] core_cnt_q;
  logic [7:0] ext_cnt_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // edge of the synchronised external clock; sync1 feeds only sync2
  wire ext_rise = sync2_q & ~sync3_q;
  wire core_wrap = core_cnt_q == CORE_LAST;
  wire ext_wrap = ext_rise & (ext_cnt_q == EXT_LAST);
  wire tick_d = tick.ext_select ? ext_wrap : core_wrap;

  // two-flop synchroniser plus one stage for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= ext_clk;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // both dividers run freely so a source switch takes effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_cnt_q <= 8'h00;
      ext_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      core_cnt_q <= core_wrap ? 8'h00 : core_cnt_q + 8'h01;
      if (ext_rise)
        ext_cnt_q <= ext_wrap ? 8'h00 : ext_cnt_q + 8'h01;
      tick_q <= tick_d;
    end
  end

  assign tick.presc_tick = tick_q;

endmodule : atr_prescale

// ---- rtl/atr_timer.sv ----
// auto-reload timer with control register, interrupts and axi4-lite slave
// How it works
// - high byte rolling ff to 00 sets the high overflow flag.
// - in 16-bit mode, full count wrapping ffff to 0000 sets high flag.
// - high flag set raises the interrupt when the timer interrupt is enabled; here only a hardware overflow does, not a software write.
// - hardware never clears either flag; software clears by writing it.
// - low byte rolling ff to 00 sets the low flag in every mode.
// - low overflow interrupts when low irq enable and timer irq enabled.
// - control bits 4 and 1 read zero and ignore writes.
// - split select 0 gives one 16-bit counter, 1 gives two 8-bit ones.
// - in 16-bit mode the counter advances only while run bit is set.
// - in split mode run gates only the high byte; low byte always runs.
// - external select 0 clocks from core clock divided by 12.
// - external select 1 clocks from external clock divided by 8, synced.
// - per-byte picks choose prescaled tick or undivided core clock.
module atr_timer
  import atr_pkg::*;
(
  input wire logic aclk, // core clock, 50 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ext_clk, // external timer clock pin
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq // level interrupt, active high
);
  import atr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by the read and write paths
  function automatic logic atr_mapped(input logic [7:0] addr);
    atr_mapped = (addr[7:2] == ATR_OFS_COUNT[7:2]) ||
      (addr[7:2] == ATR_OFS_RELOAD[7:2]) ||
      (addr[7:2] == ATR_OFS_CLKCFG[7:2]) ||
      (addr[7:2] == ATR_OFS_IRQ_STS[7:2]) ||
      (addr[7:2] == ATR_OFS_IRQ_MASK[7:2]) ||
      (addr[7:2] == ATR_OFS_CTRL[7:2]);
  endfunction : atr_mapped

  // merge written byte lanes into a 16-bit register
  function automatic logic [15:0] atr_merge16(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    atr_merge16 = {strb[1] ? data[15:8] : old[15:8],
                   strb[0] ? data[7:0] : old[7:0]};
  endfunction : atr_merge16

  atr_tick_if tick_bus ();

  atr_prescale u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_clk(ext_clk),
    .tick(tick_bus.presc)
  );

  // register state
  logic hi_flag_q;
  logic lo_flag_q;
  logic lo_irq_en_q;
  logic split_q;
  logic run_q;
  logic ext_sel_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [1:0] clkcfg_q;
  logic [1:0] sts_q;
  logic [1:0] mask_q;
  // bus state
  logic [7:0] awaddr_q;
  logic aw_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_full_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshakes; address and data may come in either order
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  // the write lands only when both halves are held and no answer waits;
  // this keeps one write in flight without an extra state bit
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
  wire aw_full_d = (aw_full_q | aw_take) & ~do_write;
  wire w_full_d = (w_full_q | w_take) & ~do_write;
  // ready stays low while a held item or a response is pending
  wire awready_d = ~aw_full_d & ~bvalid_d;
  wire wready_d = ~w_full_d & ~bvalid_d;
  wire wr_ok = atr_mapped(awaddr_q);
  wire wr_ctrl = do_write & (awaddr_q[7:2] == ATR_OFS_CTRL[7:2]) & wstrb_q[0];
  wire wr_count = do_write & (awaddr_q[7:2] == ATR_OFS_COUNT[7:2]);
  wire wr_reload = do_write & (awaddr_q[7:2] == ATR_OFS_RELOAD[7:2]);
  wire wr_clkcfg = do_write & (awaddr_q[7:2] == ATR_OFS_CLKCFG[7:2]) &
    wstrb_q[0];
  wire wr_sts = do_write & (awaddr_q[7:2] == ATR_OFS_IRQ_STS[7:2]) &
    wstrb_q[0];
  wire wr_mask = do_write & (awaddr_q[7:2] == ATR_OFS_IRQ_MASK[7:2]) &
    wstrb_q[0];

  // read channel: one read in flight, answered the cycle after it is taken
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire arready_d = ~rvalid_d;
  // only the word index is decoded; the two low address bits are ignored
  wire rd_ok = atr_mapped(s_axi_araddr);
  wire [5:0] rd_idx = s_axi_araddr[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // control readback with unused bits 4 and 1 forced to zero
  wire [7:0] ctrl_rd = {hi_flag_q, lo_flag_q, lo_irq_en_q, 1'b0,
                        split_q, run_q, 1'b0, ext_sel_q};
  wire [31:0] rdata_d =
    (rd_idx == ATR_OFS_COUNT[7:2]) ? {16'h0000, count_q} :
    (rd_idx == ATR_OFS_RELOAD[7:2]) ? {16'h0000, reload_q} :
    (rd_idx == ATR_OFS_CLKCFG[7:2]) ? {30'h0, clkcfg_q} :
    (rd_idx == ATR_OFS_IRQ_STS[7:2]) ? {30'h0, sts_q} :
    (rd_idx == ATR_OFS_IRQ_MASK[7:2]) ? {30'h0, mask_q} :
    (rd_idx == ATR_OFS_CTRL[7:2]) ? {24'h000000, ctrl_rd} :
    32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // tick choice per byte: undivided core clock or the prescaled tick
  assign tick_bus.ext_select = ext_sel_q;
  // a pick of one bypasses the prescaler, so that byte steps every enabled cycle; the high pick has no effect in 16-bit mode
  wire lo_tick = clkcfg_q[ATR_B_LO_PICK] | tick_bus.presc_tick;
  wire hi_tick = clkcfg_q[ATR_B_HI_PICK] | tick_bus.presc_tick;

  // step enables; in 16-bit mode the low pick clocks the whole counter
  wire step16 = ~split_q & run_q & lo_tick;
  wire step_lo = split_q & lo_tick;
  wire step_hi = split_q & run_q & hi_tick;
  wire [7:0] lo_cnt = count_q[7:0];
  wire [7:0] hi_cnt = count_q[15:8];
  wire wrap16 = step16 & (count_q == 16'hffff);
  wire lo_wrap = (step16 | step_lo) & (lo_cnt == 8'hff);
  wire hi_wrap = wrap16 | (step_hi & (hi_cnt == 8'hff));

  // next count: a reload replaces the rollover in the same cycle
  wire [15:0] cnt16_d = wrap16 ? reload_q : count_q + 16'h0001;
  wire [7:0] lo8_d = (lo_cnt == 8'hff) ? reload_q[7:0] :
    lo_cnt + 8'h01;
  wire [7:0] hi8_d = (hi_cnt == 8'hff) ? reload_q[15:8] :
    hi_cnt + 8'h01;
  // split mode: each byte wraps and reloads on its own
  wire [15:0] split_d = {step_hi ? hi8_d : hi_cnt,
                         step_lo ? lo8_d : lo_cnt};
  // a software write to the count wins over a step in the same cycle
  wire [15:0] count_d = wr_count ? atr_merge16(count_q, wdata_q, wstrb_q) :
    split_q ? split_d :
    step16 ? cnt16_d : count_q;

  // flags: an overflow in the same cycle as a software write still sets
  // writing a one sets a flag too, but leaves the status and interrupt untouched
  wire hi_flag_d = hi_wrap |
    (wr_ctrl ? wdata_q[ATR_B_HI_FLAG] : hi_flag_q);
  wire lo_flag_d = lo_wrap |
    (wr_ctrl ? wdata_q[ATR_B_LO_FLAG] : lo_flag_q);

  // interrupt events; the low one only counts when its enable is set
  wire [1:0] ev;
  assign ev[ATR_B_IRQ_HI] = hi_wrap;
  assign ev[ATR_B_IRQ_LO] = lo_wrap & lo_irq_en_q;
  wire [1:0] sts_clr = wr_sts ? wdata_q[1:0] : 2'h0;
  // a new event beats a software clear that falls in the same cycle
  wire [1:0] sts_d = ev | (sts_q & ~sts_clr);
  // the mask stands for the core's timer interrupt enable
  wire irq_d = |(sts_d & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // write channel holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      aw_full_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_full_q <= 1'b0;
    end else begin
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
    end
  end

  // bus answer registers; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= ATR_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ATR_RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      if (do_write)
        bresp_q <= wr_ok ? ATR_RESP_OKAY : ATR_RESP_SLVERR;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rdata_d;
        rresp_q <= rd_ok ? ATR_RESP_OKAY : ATR_RESP_SLVERR;
      end
    end
  end

  // control register; bits 4 and 1 have no storage at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_flag_q <= ATR_CTRL_RST[ATR_B_HI_FLAG];
      lo_flag_q <= ATR_CTRL_RST[ATR_B_LO_FLAG];
      lo_irq_en_q <= ATR_CTRL_RST[ATR_B_LO_IRQ_EN];
      split_q <= ATR_CTRL_RST[ATR_B_SPLIT];
      run_q <= ATR_CTRL_RST[ATR_B_RUN];
      ext_sel_q <= ATR_CTRL_RST[ATR_B_EXT_SEL];
    end else begin
      hi_flag_q <= hi_flag_d;
      lo_flag_q <= lo_flag_d;
      if (wr_ctrl) begin
        lo_irq_en_q <= wdata_q[ATR_B_LO_IRQ_EN];
        split_q <= wdata_q[ATR_B_SPLIT];
        run_q <= wdata_q[ATR_B_RUN];
        ext_sel_q <= wdata_q[ATR_B_EXT_SEL];
      end
    end
  end

  // counter, reload, clock picks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= ATR_COUNT_RST;
      reload_q <= ATR_RELOAD_RST;
      clkcfg_q <= ATR_CLKCFG_RST;
    end else begin
      count_q <= count_d;
      if (wr_reload)
        reload_q <= atr_merge16(reload_q, wdata_q, wstrb_q);
      if (wr_clkcfg)
        clkcfg_q <= wdata_q[1:0];
    end
  end

  // sticky interrupt status, mask and the registered interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= ATR_IRQ_RST;
      mask_q <= ATR_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      if (wr_mask)
        mask_q <= wdata_q[1:0];
      irq_q <= irq_d;
    end
  end

  // every port is driven straight from a flip-flop
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;

endmodule : atr_timer

// ---- verif/atr_timer_sva.sv ----
// concurrent checks on the timer's bus and interrupt ports
module atr_timer_sva
  import atr_pkg::*;
(
  input wire logic aclk, // core clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // keep the read address, since rdata arrives a cycle later
  logic [7:0] ar_q;
  logic mapped;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end
  assign mapped = ar_q inside {ATR_OFS_COUNT, ATR_OFS_RELOAD, ATR_OFS_CLKCFG,
    ATR_OFS_IRQ_STS, ATR_OFS_IRQ_MASK, ATR_OFS_CTRL};
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read channel not freed");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("second write address accepted");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  a_ctrl_spare_zero: assert property (
    s_axi_rvalid && ar_q == ATR_OFS_CTRL |-> (s_axi_rdata & 32'hffffff12) == 0)
    else $error("control spare bits read nonzero");
  a_unmapped_read: assert property (s_axi_rvalid && !mapped
    |-> s_axi_rresp == ATR_RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without a write");
endmodule : atr_timer_sva

bind atr_timer atr_timer_sva u_sva (.*);

// ---- verif/atr_timer_bench.sv ----
// self-checking bench for the auto-reload timer
module atr_timer_bench
  import atr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, ext_clk = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_v;
  int err_count = 0, checks_done = 0;
  int mdl [logic [7:0]]; // register shadow; unmapped offsets absent
  logic [7:0] ofs [6] = '{ATR_OFS_COUNT, ATR_OFS_RELOAD, ATR_OFS_CLKCFG,
    ATR_OFS_IRQ_STS, ATR_OFS_IRQ_MASK, ATR_OFS_CTRL};
  atr_timer dut (.*);
  always #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  // bus master: both write channels offered together, held till taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready)
      || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, mdl.exists(a) ? ATR_RESP_OKAY : ATR_RESP_SLVERR);
    s_axi_bready <= 1'b0;
    // status clears by ones; the rest keep only their writable bits
    if (mdl.exists(a)) mdl[a] = (a == ATR_OFS_IRQ_STS) ? mdl[a] & ~d :
      d & (a == ATR_OFS_CTRL ? 'hed : a < ATR_OFS_CLKCFG ? 'hffff : 3);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_arvalid && !s_axi_arready);
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    chk(s_axi_rresp, mdl.exists(a) ? ATR_RESP_OKAY : ATR_RESP_SLVERR);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a);
    rd(a);
    chk(rd_v, mdl[a]);
  endtask : rchk
  ////////////////////////////////////////////////////////////
  // hang guard: the whole run needs well under a thousand cycles
  initial begin
    #400000;
    err_count++;
    test_done;
  end
  initial begin
    foreach (ofs[k]) mdl[ofs[k]] = 0;
    void'($urandom(56));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values, unmapped hole, spare control bits
    foreach (ofs[k]) rchk(ofs[k]);
    rd(8'h20);
    wr(8'h20, 32'h1);
    wr(ATR_OFS_CTRL, 32'h12);
    rchk(ATR_OFS_CTRL);
    // 16-bit run from near the top: wrap, reload, flags, interrupt
    wr(ATR_OFS_RELOAD, 32'habcd);
    wr(ATR_OFS_CLKCFG, 32'h1);
    wr(ATR_OFS_COUNT, 32'hfff0);
    rchk(ATR_OFS_COUNT);
    wr(ATR_OFS_CTRL, 32'h4);
    repeat (20) @(posedge aclk);
    mdl[ATR_OFS_CTRL] = 'hc4;
    rchk(ATR_OFS_CTRL);
    wr(ATR_OFS_CTRL, 32'hc0);
    mdl[ATR_OFS_IRQ_STS] = 1;
    rchk(ATR_OFS_IRQ_STS);
    rd(ATR_OFS_COUNT);
    mdl[ATR_OFS_COUNT] = rd_v;
    chk(rd_v[15:0] inside {[16'habcd:16'hac40]}, 1);
    rchk(ATR_OFS_COUNT);
    chk(irq, 0);
    wr(ATR_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(ATR_OFS_IRQ_STS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    rchk(ATR_OFS_CTRL);
    // split: low byte runs with run clear, high byte stays put
    wr(ATR_OFS_COUNT, 32'h10f0);
    wr(ATR_OFS_CTRL, 32'h28);
    repeat (24) @(posedge aclk);
    mdl[ATR_OFS_CTRL] = 'h68;
    rchk(ATR_OFS_CTRL);
    wr(ATR_OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(ATR_OFS_CTRL, 32'h0);
    rd(ATR_OFS_COUNT);
    chk(rd_v[15:8], 8'h10);
    chk(rd_v[7:0] inside {[8'hcd:8'hf0]}, 1);
    mdl[ATR_OFS_IRQ_STS] = 2;
    rchk(ATR_OFS_IRQ_STS);
    wr(ATR_OFS_IRQ_STS, 32'h3);
    // split with run: high byte on the core clock, low byte on the tick
    wr(ATR_OFS_CLKCFG, 32'h2);
    wr(ATR_OFS_COUNT, 32'hf000);
    wr(ATR_OFS_CTRL, 32'hc);
    repeat (20) @(posedge aclk);
    mdl[ATR_OFS_CTRL] = 'h8c;
    rchk(ATR_OFS_CTRL);
    wr(ATR_OFS_CTRL, 32'h88);
    rd(ATR_OFS_COUNT);
    chk(rd_v[15:8] inside {[8'hab:8'hc0]}, 1);
    chk(rd_v[7:0] < 8'h08, 1);
    mdl[ATR_OFS_IRQ_STS] = 1;
    rchk(ATR_OFS_IRQ_STS);
    wr(ATR_OFS_IRQ_STS, 32'h3);
    // core clock divided by twelve over 240 cycles
    wr(ATR_OFS_CLKCFG, 32'h0);
    wr(ATR_OFS_COUNT, 32'h0);
    wr(ATR_OFS_CTRL, 32'h4);
    repeat (240) @(posedge aclk);
    wr(ATR_OFS_CTRL, 32'h1);
    rd(ATR_OFS_COUNT);
    chk(rd_v inside {[19:22]}, 1);
    // 24 external edges at random spacing give exactly three ticks
    wr(ATR_OFS_COUNT, 32'h0);
    wr(ATR_OFS_CTRL, 32'h5);
    repeat (24) begin
      repeat ($urandom_range(2, 5)) @(posedge aclk);
      ext_clk <= 1'b1;
      repeat ($urandom_range(2, 5)) @(posedge aclk);
      ext_clk <= 1'b0;
    end
    repeat (6) @(posedge aclk);
    wr(ATR_OFS_CTRL, 32'h1);
    rd(ATR_OFS_COUNT);
    chk(rd_v, 32'h3);
    test_done;
  end
endmodule : atr_timer_bench
